/* rtl/dgpws_top.sv */
// dual-gate pwm sequencer: register port, period timer and gate sequencing
`timescale 1ns/1ps
`default_nettype none
module dgpws_top
  import dgpws_pkg::*;
#(
  parameter int PERIOD_W = 8
) (
  // clock, reset, clock enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata_q,
  // comparator outputs
  input wire logic pwm_cmp,
  input wire logic core_saturation_detect,
  // gate-drive commands
  output logic primary_gate_drive,
  output logic secondary_gate_drive
);
  if (PERIOD_W < 3 || PERIOD_W > DATA_W) begin : g_bad_w
    $error("PERIOD_W out of range");
  end

  // register file
  logic [PERIOD_W-1:0] period_q, period_d;
  logic [PERIOD_W-1:0] duty_q, duty_d;
  logic [1:0] blank_q, blank_d;
  logic [3:0] dead_q, dead_d;
  logic [1:0] drven_q, drven_d;
  logic [2:0] satctl_q, satctl_d;
  logic [DATA_W-1:0] rdata_d;

  // time base and period timer
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [ACC_W:0] acc_sum;
  logic tick;
  logic [PERIOD_W-1:0] tmr_q, tmr_d;
  logic period_start;

  // sequencing
  dgpws_state_e st_q, st_d;
  logic [PERIOD_W-1:0] on_cnt_q, on_cnt_d;
  logic [OS_CNT_W-1:0] blank_cnt_q, blank_cnt_d;
  logic qr_q, qr_d;
  logic sat_prev_q, go_prev_q, pri_prev_q;
  logic route, wdm, sync_mode;
  logic sat_fall, os_rst, os_go, go_rise, pri_rise;
  logic limit_hit, cmp_trip, end_on, cycle_go;
  logic prim_req, sec_req;
  logic [DT_CNT_W-1:0] dt_cyc;

  // low counts cannot give N >= 4, so they are lifted to the minimum
  function automatic logic [PERIOD_W-1:0] pr_clamp(input logic [DATA_W-1:0] v);
    logic [PERIOD_W-1:0] t;
    t = v[PERIOD_W-1:0];
    return (t < PERIOD_W'(PERIOD_MIN)) ? PERIOD_W'(PERIOD_MIN) : t;
  endfunction

  // register writes and reads; read data only stand in the cycle after rd
  always_comb begin
    period_d = period_q;
    duty_d = duty_q;
    blank_d = blank_q;
    dead_d = dead_q;
    drven_d = drven_q;
    satctl_d = satctl_q;
    rdata_d = '0;
    if (wr) begin
      case (addr)
        REG_PERIOD: period_d = pr_clamp(wdata);
        REG_DUTY: duty_d = wdata[PERIOD_W-1:0];
        REG_BLANK: blank_d = wdata[1:0];
        REG_DEAD: dead_d = wdata[3:0];
        REG_DRVEN: drven_d = wdata[1:0];
        REG_SATCTL: satctl_d = wdata[2:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        REG_PERIOD: rdata_d = DATA_W'(period_q);
        REG_DUTY: rdata_d = DATA_W'(duty_q);
        REG_BLANK: rdata_d = DATA_W'(blank_q);
        REG_DEAD: rdata_d = DATA_W'(dead_q);
        REG_DRVEN: rdata_d = DATA_W'(drven_q);
        REG_SATCTL: rdata_d = DATA_W'(satctl_q);
        REG_STATUS: rdata_d = DATA_W'({st_q, os_rst, qr_q, secondary_gate_drive,
                                       primary_gate_drive});
        REG_TIMER: rdata_d = DATA_W'(tmr_q);
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      period_q <= PERIOD_W'(PERIOD_RST);
      duty_q <= PERIOD_W'(DUTY_RST);
      blank_q <= BLANK_RST;
      dead_q <= DEAD_RST;
      drven_q <= DRVEN_RST;
      satctl_q <= SAT_RST;
      rdata_q <= '0;
    end else if (ce) begin
      period_q <= period_d;
      duty_q <= duty_d;
      blank_q <= blank_d;
      dead_q <= dead_d;
      drven_q <= drven_d;
      satctl_q <= satctl_d;
      rdata_q <= rdata_d;
    end
  end

  // mode decode
  assign route = satctl_q[SAT_ROUTE];
  assign wdm = route && satctl_q[SAT_WDM];
  assign sync_mode = satctl_q[SAT_SYNC];
  assign dt_cyc = dead_cyc(dead_q);

  // 8 MHz edges from the 100 MHz clock by a phase accumulator; the tick
  // jitters by one clock but averages exactly 8 per microsecond
  always_comb begin
    acc_sum = {1'b0, acc_q} + (ACC_W + 1)'(OSC_MHZ);
    tick = acc_sum >= (ACC_W + 1)'(CLK_MHZ);
    if (tick) begin
      acc_d = ACC_W'(acc_sum - (ACC_W + 1)'(CLK_MHZ));
    end else begin
      acc_d = acc_sum[ACC_W-1:0];
    end
  end

  // period timer runs 0..period, so one period is period+1 = N ticks
  always_comb begin
    period_start = tick && (tmr_q == period_q);
    tmr_d = tmr_q;
    if (wdm && os_rst) begin
      tmr_d = '0;
    end else if (period_start) begin
      tmr_d = '0;
    end else if (tick) begin
      tmr_d = tmr_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_q <= '0;
      tmr_q <= '0;
    end else if (ce) begin
      acc_q <= acc_d;
      tmr_q <= tmr_d;
    end
  end

  // clearing pulse after primary turn-off, start pulse after saturation
  dgpws_oneshot #(
    .CNT_W(OS_CNT_W),
    .LEN(RST_PULSE_CYC)
  ) u_os_rst (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .trig(end_on),
    .pulse_q(os_rst)
  );

  dgpws_oneshot #(
    .CNT_W(OS_CNT_W),
    .LEN(GO_PULSE_CYC)
  ) u_os_go (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .trig(sat_fall),
    .pulse_q(os_go)
  );

  // edge detection; the clearing pulse masks saturation noise
  always_comb begin
    sat_fall = route && sat_prev_q && !core_saturation_detect && !os_rst;
    go_rise = os_go && !go_prev_q;
    pri_rise = primary_gate_drive && !pri_prev_q;
    // the clearing pulse wins over a saturation edge, which it masks
    if (sat_fall) begin
      qr_d = 1'b1;
    end else if (os_rst) begin
      qr_d = 1'b0;
    end else begin
      qr_d = qr_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sat_prev_q <= 1'b1;
      go_prev_q <= 1'b0;
      pri_prev_q <= 1'b0;
      qr_q <= 1'b0;
    end else if (ce) begin
      sat_prev_q <= core_saturation_detect;
      go_prev_q <= os_go;
      pri_prev_q <= primary_gate_drive;
      qr_q <= qr_d;
    end
  end

  // cycle start: timer in fixed mode, start pulse or watchdog when resonant
  always_comb begin
    if (!route) begin
      cycle_go = period_start;
    end else begin
      cycle_go = go_rise || (wdm && period_start);
    end
    limit_hit = on_cnt_q >= duty_q;
    // comparator counts only with the gate on and blanking over
    cmp_trip = !pwm_cmp && primary_gate_drive && !pri_rise
               && (blank_cnt_q == '0);
    end_on = (st_q == ST_ON) && (limit_hit || cmp_trip);
  end

  // sequencing state machine
  always_comb begin
    st_d = st_q;
    on_cnt_d = on_cnt_q;
    blank_cnt_d = blank_cnt_q;
    if (pri_rise) begin
      blank_cnt_d = leb_cyc(blank_q);
    end else if (blank_cnt_q != '0) begin
      blank_cnt_d = blank_cnt_q - 1'b1;
    end
    case (st_q)
      ST_IDLE, ST_OFF: begin
        // off phase lasts until the next cycle start
        if (cycle_go) begin
          st_d = ST_ON;
          on_cnt_d = '0;
        end
      end
      ST_ON: begin
        if (end_on) begin
          st_d = ST_OFF;
        end else if (tick && on_cnt_q != '1) begin
          on_cnt_d = on_cnt_q + 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      on_cnt_q <= '0;
      blank_cnt_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
      on_cnt_q <= on_cnt_d;
      blank_cnt_q <= blank_cnt_d;
    end
  end

  // requests are exclusive by state, so the drives can never both be asked
  assign prim_req = (st_q == ST_ON);
  assign sec_req = (st_q == ST_OFF) && sync_mode;

  dgpws_deadtime #(
    .CNT_W(DT_CNT_W)
  ) u_pri (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .en(drven_q[DRV_PRI]),
    .req(prim_req),
    .other_on(secondary_gate_drive),
    .dead_cyc_in(dt_cyc),
    .drive_q(primary_gate_drive)
  );

  dgpws_deadtime #(
    .CNT_W(DT_CNT_W)
  ) u_sec (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .en(drven_q[DRV_SEC]),
    .req(sec_req),
    .other_on(primary_gate_drive),
    .dead_cyc_in(dt_cyc),
    .drive_q(secondary_gate_drive)
  );

  // checks
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);
  // helper: ce-qualified length of the clearing pulse
  logic [OS_CNT_W:0] rst_len_q, rst_len_d;
  assign rst_len_d = os_rst ? (rst_len_q + (ce ? 1'b1 : 1'b0)) : '0;
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_len_q <= '0;
    end else begin
      rst_len_q <= rst_len_d;
    end
  end
  sequence s_on_end;
    ce && end_on;
  endsequence
  sequence s_trip;
    ce && st_q == ST_ON && cmp_trip && !limit_hit;
  endsequence
  a_gate_overlap: assert property (!(primary_gate_drive && secondary_gate_drive))
    else $error("gate drives overlap");
  a_pri_disabled: assert property (ce && !drven_q[DRV_PRI] |=> !primary_gate_drive)
    else $error("disabled primary drive asserted");
  a_sec_nonsync: assert property (ce && !sync_mode |=> !secondary_gate_drive)
    else $error("secondary drive in nonsynchronous mode");
  a_duty_cap: assert property (ce && st_q == ST_ON && limit_hit |=> st_q == ST_OFF)
    else $error("on phase ran past duty limit");
  a_blank_hold: assert property (ce && st_q == ST_ON && blank_cnt_q != '0 && !limit_hit
                                 |=> st_q == ST_ON)
    else $error("comparator acted during blanking");
  a_trip_off: assert property (s_trip ##1 ce |=> !primary_gate_drive)
    else $error("primary not off after comparator trip");
  a_rst_pulse: assert property (s_on_end |=> os_rst[*8])
    else $error("clearing pulse missing");
  a_rst_len: assert property ($fell(os_rst) |->
                              rst_len_q == (OS_CNT_W + 1)'(RST_PULSE_CYC))
    else $error("clearing pulse length wrong");
  a_sat_masked: assert property ($rose(qr_q) |-> !$past(os_rst))
    else $error("saturation edge taken during clearing pulse");
  a_go_start: assert property (ce && route && go_rise && st_q != ST_ON |=> st_q == ST_ON)
    else $error("start pulse did not start primary");
  a_wdm_clear: assert property (ce && wdm && os_rst |=> tmr_q == '0)
    else $error("watchdog timer not cleared");
  a_ff_start: assert property (ce && !route && period_start && st_q != ST_ON
                               |=> st_q == ST_ON)
    else $error("fixed mode period start missed");
  a_tmr_wrap: assert property (ce && tick && tmr_q == period_q |=> tmr_q == '0)
    else $error("period timer did not wrap at period");
endmodule // dgpws_top
`default_nettype wire

/* rtl/dgpws_pkg.sv */
// shared constants, helpers and types of the dual-gate pwm sequencer
package dgpws_pkg;
  // clock, register port and counter geometry
  localparam int CLK_MHZ = 100;
  localparam int OSC_MHZ = 8;
  localparam int ACC_W = 7;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int DT_CNT_W = 5;
  localparam int OS_CNT_W = 5;

  // timed intervals in ns, as specified
  localparam int RST_PULSE_NS = 200;
  localparam int GO_PULSE_NS = 33;
  localparam int DT_STEP_NS = 16;
  localparam int LEB_STEP_NS = 50;

  // ns to cycles: a least time rounds up and is never below one cycle
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RST_PULSE_CYC = ns2cyc(RST_PULSE_NS);
  localparam int GO_PULSE_CYC = ns2cyc(GO_PULSE_NS);

  // register offsets
  localparam logic [ADDR_W-1:0] REG_PERIOD = 4'h0;
  localparam logic [ADDR_W-1:0] REG_DUTY = 4'h1;
  localparam logic [ADDR_W-1:0] REG_BLANK = 4'h2;
  localparam logic [ADDR_W-1:0] REG_DEAD = 4'h3;
  localparam logic [ADDR_W-1:0] REG_DRVEN = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SATCTL = 4'h5;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] REG_TIMER = 4'h7;

  // field positions
  localparam int DRV_PRI = 0;
  localparam int DRV_SEC = 1;
  localparam int SAT_ROUTE = 0;
  localparam int SAT_WDM = 1;
  localparam int SAT_SYNC = 2;

  // reset values and limits
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] PERIOD_MIN = 8'h03;
  localparam logic [7:0] DUTY_RST = 8'h80;
  localparam logic [1:0] BLANK_RST = 2'h0;
  localparam logic [3:0] DEAD_RST = 4'h0;
  localparam logic [1:0] DRVEN_RST = 2'h0;
  localparam logic [2:0] SAT_RST = 3'h0;

  // dead time code c gives (c + 1) x 16 ns
  function automatic logic [DT_CNT_W-1:0] dead_cyc(input logic [3:0] code);
    return DT_CNT_W'(ns2cyc((int'(code) + 1) * DT_STEP_NS));
  endfunction

  // blanking code 0..3 gives 0, 50, 100, 200 ns
  function automatic logic [OS_CNT_W-1:0] leb_cyc(input logic [1:0] code);
    int ns;
    ns = (code == 2'h0) ? 0 : (LEB_STEP_NS << (int'(code) - 1));
    return (ns == 0) ? '0 : OS_CNT_W'(ns2cyc(ns));
  endfunction

  // sequencing states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ON = 3'h2,
    ST_OFF = 3'h4
  } dgpws_state_e;
endpackage

/* rtl/dgpws_oneshot.sv */
// fixed-length one-shot pulse generator
`timescale 1ns/1ps
`default_nettype none
module dgpws_oneshot
  import dgpws_pkg::*;
#(
  parameter int CNT_W = OS_CNT_W,
  parameter int LEN = RST_PULSE_CYC
) (
  // clock, reset, clock enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // trigger and pulse
  input wire logic trig,
  output logic pulse_q
);
  if (LEN < 1 || LEN > (1 << CNT_W)) begin : g_bad_len
    $error("one-shot length does not fit its counter");
  end

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic pulse_d;

  // a trigger inside a running pulse is ignored, the pulse is not stretched
  always_comb begin
    cnt_d = cnt_q;
    pulse_d = pulse_q;
    if (trig && !pulse_q) begin
      cnt_d = CNT_W'(LEN - 1);
      pulse_d = 1'b1;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end else begin
      pulse_d = 1'b0;
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      pulse_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      pulse_q <= pulse_d;
    end
  end
endmodule // dgpws_oneshot
`default_nettype wire

/* rtl/dgpws_deadtime.sv */
// one gate-drive output with enable and turn-on dead time
`timescale 1ns/1ps
`default_nettype none
module dgpws_deadtime
  import dgpws_pkg::*;
#(
  parameter int CNT_W = DT_CNT_W
) (
  // clock, reset, clock enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // request and the opposite drive
  input wire logic en,
  input wire logic req,
  input wire logic other_on,
  input wire logic [CNT_W-1:0] dead_cyc_in,
  // registered gate command
  output logic drive_q
);
  if (CNT_W < 1) begin : g_bad_w
    $error("dead time counter too narrow");
  end

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic drive_d;

  // count cycles the other gate has been off; turn-off is immediate
  always_comb begin
    if (other_on) begin
      cnt_d = '0;
    end else if (cnt_q >= dead_cyc_in) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
    drive_d = en && req && !other_on && (cnt_q >= dead_cyc_in);
  end

  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      drive_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      drive_q <= drive_d;
    end
  end
endmodule // dgpws_deadtime
`default_nettype wire

/* sim/dgpws_partner.sv */
// comparator stand-in at the gate side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module dgpws_partner (
  // clock
  input wire logic clk,
  // gate commands seen
  input wire logic pri,
  input wire logic sec,
  // behaviour knobs from the bench
  input wire logic [7:0] trip_dly,
  input wire logic sat_en,
  input wire logic [7:0] sat_dly,
  // comparator outputs
  output logic pwm_cmp = 1'b1,
  output logic sat_n = 1'b1
);
  int pc = 0;
  int sc = 0;
  int oc = 0;
  // on time of each gate and off time of the primary, cleared as the gate changes
  always @(posedge clk) begin
    pc <= pri ? pc + 1 : 0;
    sc <= sec ? sc + 1 : 0;
    oc <= pri ? 0 : oc + 1;
  end
  // current ramps while primary conducts; delay 0 never reaches the level
  always @(posedge clk) begin
    pwm_cmp <= !(pri && trip_dly != 8'h00 && pc >= int'(trip_dly));
  end
  // winding runs dry in secondary conduction; a ringing spike five cycles
  // after primary off has to be masked by the sequencer
  always @(posedge clk) begin
    sat_n <= !((sat_en && sec && sc >= int'(sat_dly)) || oc == 5);
  end
endmodule // dgpws_partner
`default_nettype wire

/* sim/dgpws_top_tb.sv */
// self-checking bench of the dual-gate pwm sequencer
`timescale 1ns/1ps
`default_nettype none
module dgpws_top_tb
  import dgpws_pkg::*;
;
  logic clk = 1'b0;
  logic srst, ce, wr, rd, sat_en, pri, sec, pwm_cmp, sat_n;
  logic [3:0] addr;
  logic [7:0] wdata, rdata_q, trip_dly, sat_dly;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int ovl = 0;

  // 100 MHz clock
  always #5 clk = ~clk;
  // cycle stamp and a tally of gate overlap, read at the falling edge
  always @(posedge clk) cyc <= cyc + 1;
  always @(negedge clk) if (pri === 1'b1 && sec === 1'b1) ovl++;

  dgpws_top #(.PERIOD_W(8)) DUT (.clk(clk), .srst(srst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .pwm_cmp(pwm_cmp),
    .core_saturation_detect(sat_n), .primary_gate_drive(pri),
    .secondary_gate_drive(sec));
  dgpws_partner PM (.clk(clk), .pri(pri), .sec(sec), .trip_dly(trip_dly),
    .sat_en(sat_en), .sat_dly(sat_dly), .pwm_cmp(pwm_cmp), .sat_n(sat_n));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic in_range(input string what, input int v, input int lo, input int hi);
    check(what, 16'(v), (v >= lo && v <= hi) ? 16'(v) : 16'(lo));
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(what, {8'h00, rdata_q}, {8'h00, exp});
  endtask
  task automatic knobs(input logic [7:0] t, input logic e, input logic [7:0] d);
    @(posedge clk);
    trip_dly <= t;
    sat_en <= e;
    sat_dly <= d;
  endtask
  // wait for a gate to reach level v from the other level, bounded
  task automatic edge_t(input bit s, input logic v, input int lim, output int t);
    int n;
    n = 0;
    while (((s ? sec : pri) === v) && n < lim) begin
      @(negedge clk);
      n++;
    end
    while (((s ? sec : pri) !== v) && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) check("gate edge wait", 16'h0000, 16'h0001);
    t = cyc;
  endtask
  task automatic hold(input int n, output int p, output int s);
    p = 0;
    s = 0;
    repeat (n) begin
      @(negedge clk);
      p += (pri === 1'b1);
      s += (sec === 1'b1);
    end
  endtask

  task automatic t_regs();
    rd_chk("period", REG_PERIOD, PERIOD_RST);
    rd_chk("duty", REG_DUTY, DUTY_RST);
    rd_chk("blank", REG_BLANK, 8'h00);
    rd_chk("dead", REG_DEAD, 8'h00);
    rd_chk("drven", REG_DRVEN, 8'h00);
    rd_chk("satctl", REG_SATCTL, 8'h00);
    rd_chk("status", REG_STATUS, 8'h10);
    wr_reg(REG_PERIOD, 8'h00);
    rd_chk("period floor", REG_PERIOD, 8'h03);
    wr_reg(REG_BLANK, 8'hff);
    rd_chk("blank width", REG_BLANK, 8'h03);
    wr_reg(REG_STATUS, 8'hff);
    rd_chk("status ro", REG_STATUS, 8'h10);
    wr_reg(4'h8, 8'hff);
    rd_chk("unmapped", 4'h8, 8'h00);
    @(posedge clk) ce <= 1'b0;
    wr_reg(REG_DUTY, 8'h11);
    @(posedge clk) ce <= 1'b1;
    rd_chk("duty frozen", REG_DUTY, DUTY_RST);
    wr_reg(REG_BLANK, 8'h00);
    $display("test regs done");
  endtask

  // rise to rise spacing is N periods of the 8 MHz tick
  task automatic t_period();
    logic [7:0] n[3] = '{8'h03, 8'h07, 8'hff};
    int t0, t1;
    knobs(8'h05, 1'b0, 8'h00);
    wr_reg(REG_DRVEN, 8'h01);
    foreach (n[i]) begin
      wr_reg(REG_PERIOD, n[i]);
      edge_t(0, 1'b1, 7000, t0);
      edge_t(0, 1'b1, 7000, t0);
      edge_t(0, 1'b1, 7000, t1);
      in_range("period", t1 - t0, (int'(n[i]) + 1) * 100 / 8,
               (int'(n[i]) + 1) * 100 / 8);
    end
    $display("test period done");
  endtask

  // no trip: the duty limit alone ends the on phase
  task automatic t_duty();
    int d[2] = '{2, 4};
    int t0, t1;
    knobs(8'h00, 1'b0, 8'h00);
    wr_reg(REG_PERIOD, 8'h07);
    foreach (d[i]) begin
      wr_reg(REG_DUTY, 8'(d[i]));
      edge_t(0, 1'b1, 400, t0);
      edge_t(0, 1'b0, 400, t1);
      in_range("duty on time", t1 - t0, d[i] * 100 / 8 - 4, d[i] * 100 / 8 + 3);
    end
    wr_reg(REG_DUTY, 8'h80);
    $display("test duty done");
  endtask

  // trip one cycle in; blanking stretches the on time to its length
  task automatic t_blank();
    int b[4] = '{0, 5, 10, 20};
    int t0, t1;
    knobs(8'h01, 1'b0, 8'h00);
    foreach (b[i]) begin
      wr_reg(REG_BLANK, 8'(i));
      edge_t(0, 1'b1, 400, t0);
      edge_t(0, 1'b1, 400, t0);
      edge_t(0, 1'b0, 400, t1);
      in_range("blanked on time", t1 - t0, b[i], b[i] + 6);
    end
    wr_reg(REG_BLANK, 8'h00);
    $display("test blank done");
  endtask

  // enable and mode table: {secondary, primary} expected to switch
  task automatic t_enable();
    logic [7:0] en[4] = '{8'h00, 8'h03, 8'h01, 8'h03};
    logic [7:0] sc[4] = '{8'h00, 8'h00, 8'h04, 8'h04};
    logic [1:0] ex[4] = '{2'b00, 2'b01, 2'b01, 2'b11};
    int p, s;
    foreach (en[i]) begin
      wr_reg(REG_DRVEN, en[i]);
      wr_reg(REG_SATCTL, sc[i]);
      hold(400, p, s);
      hold(400, p, s);
      check("primary switching", 16'(p != 0), 16'(ex[i][0]));
      check("secondary switching", 16'(s != 0), 16'(ex[i][1]));
    end
    $display("test enable done");
  endtask

  // resonant synchronous cycle, short and long dead time
  task automatic t_qr();
    logic [7:0] c[2] = '{8'h00, 8'h0f};
    int dc, t0, t1, t2, t3;
    wr_reg(REG_PERIOD, 8'hff);
    knobs(8'h0a, 1'b1, 8'h1e);
    wr_reg(REG_SATCTL, 8'h07);
    foreach (c[i]) begin
      wr_reg(REG_DEAD, c[i]);
      dc = ((int'(c[i]) + 1) * 16 + 9) / 10;
      edge_t(0, 1'b1, 8000, t0);
      edge_t(0, 1'b0, 400, t0);
      edge_t(1, 1'b1, 400, t1);
      edge_t(1, 1'b0, 400, t2);
      edge_t(0, 1'b1, 400, t3);
      in_range("pri off to sec on", t1 - t0, dc, dc + 3);
      in_range("sec on time", t2 - t1, 30, 36);
      in_range("sec off to pri on", t3 - t2, dc, dc + 3);
    end
    $display("test resonant done");
  endtask

  // no saturation event: the timer restarts only in watchdog mode
  task automatic t_wdog();
    int t0, t1, p, s;
    knobs(8'h0a, 1'b0, 8'h1e);
    wr_reg(REG_PERIOD, 8'h07);
    edge_t(0, 1'b0, 400, t0);
    edge_t(0, 1'b1, 400, t0);
    edge_t(0, 1'b0, 400, t0);
    edge_t(0, 1'b1, 400, t1);
    in_range("watchdog restart", t1 - t0, 95, 200);
    wr_reg(REG_SATCTL, 8'h05);
    edge_t(0, 1'b0, 400, t0);
    hold(600, p, s);
    check("no restart", 16'(p), 16'h0000);
    check("gate overlap", 16'(ovl), 16'h0000);
    $display("test watchdog done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // runaway guard, well beyond the expected run length
  initial begin
    #800000;
    err_count++;
    report_and_stop();
  end

  // reset, then the scenarios in order
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    trip_dly = 8'h00;
    sat_en = 1'b0;
    sat_dly = 8'h00;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_period();
    t_duty();
    t_blank();
    t_enable();
    t_qr();
    t_wdog();
    report_and_stop();
  end
endmodule // dgpws_top_tb
`default_nettype wire
